// ---- dac_mod_ctrl.sv ----
// One main DAC's copy of the modulator controls plus its load request.
// Assumes the bank above decodes strobes; this copy gates them by its page bit.
`timescale 1ns/1ps
`include "mod_ctrl_cfg.svh"

module dac_mod_ctrl (
  input wire logic sys_clk_in, // Digital clock
  input wire logic reset_in, // Sync reset, active high
  input wire logic sel_in, // This DAC is paged in
  input wire logic cfg_wr_in, // Config register write
  input wire logic upd_wr_in, // Update register write
  input wire logic tuning_msb_wr_in, // Tuning word top byte written
  input wire mod_ctrl_pkg::byte_t wr_data_in, // Write data
  output mod_ctrl_pkg::mod_ctrl_s ctrl_out, // Held controls
  output logic load_req_out // One-cycle load request
);

  // One flop per field, so each process owns everything it writes
  logic osc_en_r;
  logic modulus_en_r;
  mod_ctrl_pkg::sideband_e sideband_r;
  logic req_mode_r;
  logic load_req_r;

  // ==========================================================
  // Config fields; only the paged copy takes a write
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      osc_en_r <= `OSC_EN_RST;
      modulus_en_r <= `MODULUS_EN_RST;
      sideband_r <= mod_ctrl_pkg::SIDEBAND_UPPER;
    end else if (sel_in && cfg_wr_in) begin
      osc_en_r <= wr_data_in[`OSC_EN_BIT];
      modulus_en_r <= wr_data_in[`MODULUS_EN_BIT];
      sideband_r <= mod_ctrl_pkg::sideband_e'(wr_data_in[`SIDEBAND_BIT]);
    end
  end

  // Request mode lives in the update register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      req_mode_r <= `REQ_MODE_RST;
    end else if (sel_in && upd_wr_in) begin
      req_mode_r <= wr_data_in[`REQ_MODE_BIT];
    end
  end

  // ==========================================================
  // Load request: manual write of the request bit, or automatic
  // on the top tuning byte when request mode is set
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      load_req_r <= 1'b0;
    end else begin
      load_req_r <= sel_in && ((upd_wr_in && wr_data_in[`LOAD_REQ_BIT]) ||
        (tuning_msb_wr_in && req_mode_r));
    end
  end

  assign ctrl_out = '{
    main_path_osc_enable: osc_en_r,
    modulus_enable: modulus_en_r,
    sideband_select: sideband_r,
    tuning_load_request_mode: req_mode_r
  };
  assign load_req_out = load_req_r;

endmodule

// ---- main_path_nco_mod_control.sv ----
// Main path modulator control bank for a dual main DAC datapath.
// Assumes a plain register port master on the same clock, and that
// reset_in is the digital datapath reset, held until clocks are stable.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "mod_ctrl_cfg.svh"

module main_path_nco_mod_control (
  input wire logic sys_clk_in, // 250 MHz digital clock
  input wire logic reset_in, // Sync reset, active high
  input wire mod_ctrl_pkg::addr_t addr_in, // Register address
  input wire mod_ctrl_pkg::byte_t wr_data_in, // Register write data
  input wire logic wr_en_in, // Write strobe, one cycle
  input wire logic rd_en_in, // Read strobe, one cycle
  output mod_ctrl_pkg::byte_t rd_data_out, // Read data, next cycle
  output mod_ctrl_pkg::page_t page_sel_out, // Current page field
  output mod_ctrl_pkg::mod_ctrl_s dac0_ctrl_out, // DAC0 controls
  output mod_ctrl_pkg::mod_ctrl_s dac1_ctrl_out, // DAC1 controls
  output logic dac0_load_req_out, // DAC0 tuning load pulse
  output logic dac1_load_req_out // DAC1 tuning load pulse
);

  // ==========================================================
  // Strobe decode
  logic page_wr;
  logic cfg_wr;
  logic upd_wr;
  logic msb_wr;
  mod_ctrl_pkg::page_t page_r;
  mod_ctrl_pkg::byte_t rd_data_r;
  mod_ctrl_pkg::byte_t rd_mux;
  mod_ctrl_pkg::mod_ctrl_s rd_ctrl;

  // Address decode as a priority chain; all targets are exclusive
  always_comb begin
    page_wr = 1'b0;
    cfg_wr = 1'b0;
    upd_wr = 1'b0;
    msb_wr = 1'b0;
    if (!wr_en_in) begin
      page_wr = 1'b0;
    end else if (addr_in == `PAGE_ADDR) begin
      page_wr = 1'b1;
    end else if (addr_in == `CFG_ADDR) begin
      cfg_wr = 1'b1;
    end else if (addr_in == `UPD_ADDR) begin
      upd_wr = 1'b1;
    end else if (addr_in == `TUNING_MSB_ADDR) begin
      msb_wr = 1'b1; // Word itself is stored elsewhere
    end
  end

  // ==========================================================
  // Page field; both bits set writes both copies at once
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      page_r <= `PAGE_RST;
    end else if (page_wr) begin
      page_r <= wr_data_in[1:0];
    end
  end

  // ==========================================================
  // Per-DAC copies
  dac_mod_ctrl u_dac0 (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .sel_in(page_r[`PAGE_DAC0_BIT]),
    .cfg_wr_in(cfg_wr),
    .upd_wr_in(upd_wr),
    .tuning_msb_wr_in(msb_wr),
    .wr_data_in(wr_data_in),
    .ctrl_out(dac0_ctrl_out),
    .load_req_out(dac0_load_req_out)
  );

  dac_mod_ctrl u_dac1 (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .sel_in(page_r[`PAGE_DAC1_BIT]),
    .cfg_wr_in(cfg_wr),
    .upd_wr_in(upd_wr),
    .tuning_msb_wr_in(msb_wr),
    .wr_data_in(wr_data_in),
    .ctrl_out(dac1_ctrl_out),
    .load_req_out(dac1_load_req_out)
  );

  // ==========================================================
  // Read-back; with both pages set the DAC0 copy is shown,
  // since one byte cannot show two copies
  always_comb begin
    rd_ctrl = page_r[`PAGE_DAC0_BIT] ? dac0_ctrl_out : dac1_ctrl_out;
    rd_mux = 8'h00;
    if (addr_in == `PAGE_ADDR) begin
      rd_mux[1:0] = page_r;
    end else if (addr_in == `CFG_ADDR) begin
      rd_mux[`OSC_EN_BIT] = rd_ctrl.main_path_osc_enable;
      rd_mux[`MODULUS_EN_BIT] = rd_ctrl.modulus_enable;
      rd_mux[`SIDEBAND_BIT] = rd_ctrl.sideband_select;
    end else if (addr_in == `UPD_ADDR) begin
      rd_mux[`REQ_MODE_BIT] = rd_ctrl.tuning_load_request_mode;
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_data_r <= 8'h00;
    end else if (rd_en_in) begin
      rd_data_r <= rd_mux;
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign rd_data_out = rd_data_r;
  assign page_sel_out = page_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_osc_follows;
    cfg_wr && page_r[`PAGE_DAC0_BIT] |=>
      dac0_ctrl_out.main_path_osc_enable == $past(wr_data_in[`OSC_EN_BIT]);
  endproperty
  a_osc_follows: assert property (p_osc_follows)
    else $error("DAC0 oscillator enable did not follow write");

  property p_page_isolation;
    cfg_wr && !page_r[`PAGE_DAC1_BIT] && !upd_wr |=> $stable(dac1_ctrl_out);
  endproperty
  a_page_isolation: assert property (p_page_isolation)
    else $error("Unpaged DAC1 controls changed");

  property p_modulus_follows;
    cfg_wr && page_r[`PAGE_DAC1_BIT] |=>
      dac1_ctrl_out.modulus_enable == $past(wr_data_in[`MODULUS_EN_BIT]);
  endproperty
  a_modulus_follows: assert property (p_modulus_follows)
    else $error("DAC1 modulus enable did not follow write");

  property p_auto_req;
    msb_wr && page_r[`PAGE_DAC0_BIT] && dac0_ctrl_out.tuning_load_request_mode
      |=> dac0_load_req_out;
  endproperty
  a_auto_req: assert property (p_auto_req)
    else $error("No automatic load request after top tuning byte");

  property p_no_auto_req;
    msb_wr && !dac0_ctrl_out.tuning_load_request_mode |=> !dac0_load_req_out;
  endproperty
  a_no_auto_req: assert property (p_no_auto_req)
    else $error("Load request raised with request mode off");

  property p_sideband_follows;
    cfg_wr && page_r[`PAGE_DAC1_BIT] |=>
      dac1_ctrl_out.sideband_select == $past(wr_data_in[`SIDEBAND_BIT]);
  endproperty
  a_sideband_follows: assert property (p_sideband_follows)
    else $error("DAC1 sideband select did not follow write");

  property p_readback;
    rd_en_in && addr_in == `CFG_ADDR && page_r[`PAGE_DAC0_BIT] ##1 1'b1 |->
      rd_data_out[`OSC_EN_BIT] == $past(dac0_ctrl_out.main_path_osc_enable);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Read-back does not show paged DAC0 copy");

  // ==========================================================
  // Remaining fields of both copies
  property p_osc_follows_dac1;
    cfg_wr && page_r[`PAGE_DAC1_BIT] |=>
      dac1_ctrl_out.main_path_osc_enable == $past(wr_data_in[`OSC_EN_BIT]);
  endproperty
  a_osc_follows_dac1: assert property (p_osc_follows_dac1)
    else $error("DAC1 oscillator enable did not follow write");

  property p_modulus_follows_dac0;
    cfg_wr && page_r[`PAGE_DAC0_BIT] |=>
      dac0_ctrl_out.modulus_enable == $past(wr_data_in[`MODULUS_EN_BIT]);
  endproperty
  a_modulus_follows_dac0: assert property (p_modulus_follows_dac0)
    else $error("DAC0 modulus enable did not follow write");

  property p_sideband_follows_dac0;
    cfg_wr && page_r[`PAGE_DAC0_BIT] |=>
      dac0_ctrl_out.sideband_select == $past(wr_data_in[`SIDEBAND_BIT]);
  endproperty
  a_sideband_follows_dac0: assert property (p_sideband_follows_dac0)
    else $error("DAC0 sideband select did not follow write");

  property p_dac0_hold;
    !cfg_wr && !upd_wr |=> $stable(dac0_ctrl_out);
  endproperty
  a_dac0_hold: assert property (p_dac0_hold)
    else $error("DAC0 controls changed without a write");

  property p_dac1_hold;
    !cfg_wr && !upd_wr |=> $stable(dac1_ctrl_out);
  endproperty
  a_dac1_hold: assert property (p_dac1_hold)
    else $error("DAC1 controls changed without a write");

  // ==========================================================
  // Paging and read-back
  property p_page_follows;
    page_wr |=> page_r == $past(wr_data_in[1:0]);
  endproperty
  a_page_follows: assert property (p_page_follows)
    else $error("Page field did not follow write");

  property p_page_isolation_dac0;
    cfg_wr && !page_r[`PAGE_DAC0_BIT] |=> $stable(dac0_ctrl_out);
  endproperty
  a_page_isolation_dac0: assert property (p_page_isolation_dac0)
    else $error("Unpaged DAC0 controls changed");

  property p_both_pages;
    cfg_wr && page_r == 2'h3 |=>
      dac0_ctrl_out.main_path_osc_enable == dac1_ctrl_out.main_path_osc_enable;
  endproperty
  a_both_pages: assert property (p_both_pages)
    else $error("Shared write left the copies different");

  property p_unpaged_no_req_dac1;
    !page_r[`PAGE_DAC1_BIT] |=> !dac1_load_req_out;
  endproperty
  a_unpaged_no_req_dac1: assert property (p_unpaged_no_req_dac1)
    else $error("Unpaged DAC1 raised a load request");

  property p_readback_dac1;
    rd_en_in && addr_in == `CFG_ADDR && !page_r[`PAGE_DAC0_BIT] ##1 1'b1 |->
      rd_data_out[`MODULUS_EN_BIT] == $past(dac1_ctrl_out.modulus_enable);
  endproperty
  a_readback_dac1: assert property (p_readback_dac1)
    else $error("Read-back does not show paged DAC1 copy");

  // ==========================================================
  // Load requests
  property p_req_mode_follows_dac0;
    upd_wr && page_r[`PAGE_DAC0_BIT] |=>
      dac0_ctrl_out.tuning_load_request_mode == $past(wr_data_in[`REQ_MODE_BIT]);
  endproperty
  a_req_mode_follows_dac0: assert property (p_req_mode_follows_dac0)
    else $error("DAC0 request mode did not follow write");

  property p_req_mode_follows_dac1;
    upd_wr && page_r[`PAGE_DAC1_BIT] |=>
      dac1_ctrl_out.tuning_load_request_mode == $past(wr_data_in[`REQ_MODE_BIT]);
  endproperty
  a_req_mode_follows_dac1: assert property (p_req_mode_follows_dac1)
    else $error("DAC1 request mode did not follow write");

  property p_auto_req_dac1;
    msb_wr && page_r[`PAGE_DAC1_BIT] && dac1_ctrl_out.tuning_load_request_mode
      |=> dac1_load_req_out;
  endproperty
  a_auto_req_dac1: assert property (p_auto_req_dac1)
    else $error("No DAC1 automatic load request after top tuning byte");

  property p_no_auto_req_dac1;
    msb_wr && !dac1_ctrl_out.tuning_load_request_mode |=> !dac1_load_req_out;
  endproperty
  a_no_auto_req_dac1: assert property (p_no_auto_req_dac1)
    else $error("DAC1 load request raised with request mode off");

  property p_manual_req;
    upd_wr && page_r[`PAGE_DAC0_BIT] && wr_data_in[`LOAD_REQ_BIT]
      |=> dac0_load_req_out;
  endproperty
  a_manual_req: assert property (p_manual_req)
    else $error("Manual load request did not pulse DAC0");

  property p_req_needs_write;
    !msb_wr && !upd_wr |=> !dac0_load_req_out;
  endproperty
  a_req_needs_write: assert property (p_req_needs_write)
    else $error("DAC0 load request without a write");

  property p_req_needs_write_dac1;
    !msb_wr && !upd_wr |=> !dac1_load_req_out;
  endproperty
  a_req_needs_write_dac1: assert property (p_req_needs_write_dac1)
    else $error("DAC1 load request without a write");

  // ==========================================================
  // Main scenarios
  c_auto_req: cover property (msb_wr ##1 dac1_load_req_out);
  c_both_pages: cover property (cfg_wr && page_r == 2'h3);
  c_lower_band: cover property (dac0_ctrl_out.sideband_select &&
    dac0_ctrl_out.main_path_osc_enable);
  c_dac1_manual: cover property (upd_wr && page_r[`PAGE_DAC1_BIT] ##1
    dac1_load_req_out);
  c_read_both: cover property (rd_en_in && page_r == 2'h3);

endmodule

// ---- mod_ctrl_cfg.svh ----
// Register offsets, field positions, reset values for the main path
// modulator control bank. Definitions only; included by bare name.
`ifndef MOD_CTRL_CFG_SVH
`define MOD_CTRL_CFG_SVH

// ==========================================================
// Register offsets (12-bit register address space)
`define PAGE_ADDR 12'h008
`define CFG_ADDR 12'h112
`define UPD_ADDR 12'h113
`define TUNING_MSB_ADDR 12'h118

// ==========================================================
// Field positions
`define PAGE_DAC0_BIT 0
`define PAGE_DAC1_BIT 1
`define OSC_EN_BIT 3
`define MODULUS_EN_BIT 2
`define SIDEBAND_BIT 1
`define REQ_MODE_BIT 2
`define LOAD_REQ_BIT 0

// ==========================================================
// Reset values
`define PAGE_RST 2'h1
`define OSC_EN_RST 1'h0
`define MODULUS_EN_RST 1'h0
`define SIDEBAND_RST 1'h0
`define REQ_MODE_RST 1'h0

`endif

// ---- mod_ctrl_pkg.sv ----
// Types shared by the modulator control bank and its per-DAC copies.
// Assumes the offsets and reset values come from mod_ctrl_cfg.svh.
package mod_ctrl_pkg;

  // ==========================================================
  // Sideband choice; upper is the power-on choice
  typedef enum logic {
    SIDEBAND_UPPER = 1'b0,
    SIDEBAND_LOWER = 1'b1
  } sideband_e;

  // ==========================================================
  // Controls held per main DAC
  typedef struct packed {
    logic main_path_osc_enable;
    logic modulus_enable;
    sideband_e sideband_select;
    logic tuning_load_request_mode;
  } mod_ctrl_s;

  typedef logic [1:0] page_t;
  typedef logic [7:0] byte_t;
  typedef logic [11:0] addr_t;

endpackage

// ---- tb_top.sv ----
// Self-checking bench for the main path modulator control bank.
// Assumes the bank drives no wait states and reads back one cycle late.
`timescale 1ns/1ps
`include "mod_ctrl_cfg.svh"

module tb_top;
  // ==========================================================
  // Bench signals
  logic clk;
  logic rst;
  mod_ctrl_pkg::addr_t addr;
  mod_ctrl_pkg::byte_t wr_data;
  logic wr_en;
  logic rd_en;
  mod_ctrl_pkg::byte_t rd_data;
  mod_ctrl_pkg::page_t page_sel;
  mod_ctrl_pkg::mod_ctrl_s dac0_ctrl;
  mod_ctrl_pkg::mod_ctrl_s dac1_ctrl;
  logic dac0_req;
  logic dac1_req;
  int n_fail;
  int n_tests;

  main_path_nco_mod_control DUT (
    .sys_clk_in(clk),
    .reset_in(rst),
    .addr_in(addr),
    .wr_data_in(wr_data),
    .wr_en_in(wr_en),
    .rd_en_in(rd_en),
    .rd_data_out(rd_data),
    .page_sel_out(page_sel),
    .dac0_ctrl_out(dac0_ctrl),
    .dac1_ctrl_out(dac1_ctrl),
    .dac0_load_req_out(dac0_req),
    .dac1_load_req_out(dac1_req)
  );

  // ==========================================================
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  // Case inequality so an unknown never passes
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  // Leaves the caller 1 ns past the edge that took the write
  task automatic wr(input mod_ctrl_pkg::addr_t a, input mod_ctrl_pkg::byte_t d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // Data stands one cycle only, so it is checked there, then for 0x00
  task automatic rd(input mod_ctrl_pkg::addr_t a, input mod_ctrl_pkg::byte_t exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
    @(posedge clk);
    #1;
    chk(rd_data, 8'h00);
  endtask

  task automatic ctl(input logic [3:0] e0, input logic [3:0] e1);
    chk({4'h0, dac0_ctrl}, {4'h0, e0});
    chk({4'h0, dac1_ctrl}, {4'h0, e1});
  endtask

  task automatic req(input logic e0, input logic e1);
    chk({6'h00, dac1_req, dac0_req}, {6'h00, e1, e0});
  endtask

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog; the tests need well under 300 cycles
  initial begin
    #20000;
    n_fail++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    rst = 1'b1;
    addr = 12'h000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({6'h00, page_sel}, 8'h01);
    ctl(4'h0, 4'h0);
    req(1'b0, 1'b0);
    rd(`PAGE_ADDR, 8'h01);
    rd(`CFG_ADDR, 8'h00);
    rd(`UPD_ADDR, 8'h00);
    // All ones: unimplemented mode and reserved bits must read 0
    wr(`CFG_ADDR, 8'hFF);
    ctl(4'hE, 4'h0);
    rd(`CFG_ADDR, 8'h0E);
    // Oscillator on for the first path in use
    wr(`CFG_ADDR, 8'h08);
    ctl(4'h8, 4'h0);
    // Second DAC paged in alone
    wr(`PAGE_ADDR, 8'h02);
    chk({6'h00, page_sel}, 8'h02);
    wr(`CFG_ADDR, 8'h04);
    ctl(4'h8, 4'h4);
    rd(`CFG_ADDR, 8'h04);
    // Empty page writes nothing; unmapped place is ignored
    wr(`PAGE_ADDR, 8'h00);
    wr(`CFG_ADDR, 8'h0E);
    ctl(4'h8, 4'h4);
    wr(12'hFFF, 8'hFF);
    rd(12'hFFF, 8'h00);
    chk({6'h00, page_sel}, 8'h00);
    // Top tuning byte with request mode off gives no pulse
    wr(`PAGE_ADDR, 8'h01);
    wr(`TUNING_MSB_ADDR, 8'hAA);
    req(1'b0, 1'b0);
    wr(`UPD_ADDR, 8'h04);
    ctl(4'h9, 4'h4);
    rd(`UPD_ADDR, 8'h04);
    // Back to back top byte writes give back to back pulses
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= `TUNING_MSB_ADDR;
    @(posedge clk);
    #1;
    req(1'b1, 1'b0);
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
    req(1'b1, 1'b0);
    @(posedge clk);
    #1;
    req(1'b0, 1'b0);
    // Manual request keeps the mode bit set
    wr(`UPD_ADDR, 8'h05);
    req(1'b1, 1'b0);
    ctl(4'h9, 4'h4);
    // Both pages: shared write, pulse only where mode is on
    wr(`PAGE_ADDR, 8'h03);
    wr(`CFG_ADDR, 8'h02);
    ctl(4'h3, 4'h2);
    wr(`TUNING_MSB_ADDR, 8'h55);
    req(1'b1, 1'b0);
    @(posedge clk);
    #1;
    req(1'b0, 1'b0);
    // Both pages read back the first copy only
    rd(`CFG_ADDR, 8'h02);
    // Second path in use: oscillator on, zero shift, own requests
    wr(`PAGE_ADDR, 8'h02);
    wr(`CFG_ADDR, 8'h08);
    ctl(4'h3, 4'h8);
    wr(`UPD_ADDR, 8'h05);
    req(1'b0, 1'b1);
    ctl(4'h3, 4'h9);
    rd(`UPD_ADDR, 8'h04);
    wr(`TUNING_MSB_ADDR, 8'h00);
    req(1'b0, 1'b1);
    @(posedge clk);
    #1;
    req(1'b0, 1'b0);
    results();
  end
endmodule
